// ---- design/rcs_pkg.sv ----
// Purpose: Constants and types shared by the reset and clock source control block
// Assumes: System clock mclk at 10 MHz
// Notes:   Register data is 8 bits wide, addresses are 4 bits wide
package rcs_pkg;
    localparam int CLK_PERIOD_NS  = 100;
    localparam int RST_HOLD_NS    = 1000;
    localparam int RST_HOLD_CYC   = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CLK_SETTLE_NS  = 500;
    localparam int CLK_SETTLE_CYC = (CLK_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_EN   = 4'h1;
    localparam logic [3:0] ADDR_CLK  = 4'h2;
    localparam logic [3:0] ADDR_STAT = 4'h3;
    localparam logic [3:0] ADDR_MASK = 4'h4;
    localparam logic [3:0] ADDR_LIVE = 4'h5;

    localparam int CTRL_SWRST = 0;
    localparam int CTRL_WLOCK = 1;

    localparam int EN_WDT = 0;
    localparam int EN_MCD = 1;
    localparam int EN_CMP = 2;
    localparam int EN_SW  = 3;
    localparam int EN_CNV = 4;
    localparam logic [4:0] EN_RST = 5'h0b;

    localparam int C_POR = 0;
    localparam int C_SUP = 1;
    localparam int C_WDT = 2;
    localparam int C_MCD = 3;
    localparam int C_CMP = 4;
    localparam int C_SW  = 5;
    localparam int C_CNV = 6;
    localparam int C_EXT = 7;
    localparam logic [7:0] STAT_RST = 8'h01;
    localparam logic [7:0] MASK_RST = 8'h00;

    localparam int S_EXT = 0;
    localparam int S_SUP = 1;
    localparam int S_MON = 2;
    localparam int S_MCD = 3;
    localparam int S_CMP = 4;
    localparam int S_CNV = 5;

    typedef enum logic [1:0] {SRC_INT, SRC_EXT, SRC_PLL} rcs_src_e;
endpackage : rcs_pkg

// ---- design/rcs_clk_if.sv ----
// Purpose: Carries clock source request and selector state between control and selector
// Assumes: Single clock domain mclk
// Notes:   No clocking block
`timescale 1ns/10ps
interface rcs_clk_if;
    import rcs_pkg::*;
    rcs_src_e req_src;
    rcs_src_e cur_src;
    logic     gate_en;
    logic     busy;
    modport ctl (output req_src, input cur_src, input gate_en, input busy);
    modport sel (input req_src, output cur_src, output gate_en, output busy);
endinterface : rcs_clk_if

// ---- design/rcs_clk_sel.sv ----
// Purpose: Break-before-make sequencing of the system clock source select
// Assumes: The clock mux downstream is gated by gate_en and switched by cur_src
// Notes:   Source changes only while the gate has been closed for the settle time
`timescale 1ns/10ps
module rcs_clk_sel import rcs_pkg::*; #(
    parameter int SETTLE_CYC = CLK_SETTLE_CYC
) (
    input  wire logic mclk,
    input  wire logic rst_n,
    rcs_clk_if.sel    cif
);
    localparam int SW = $clog2(SETTLE_CYC + 1);
    typedef enum logic [1:0] {ST_RUN, ST_OFF, ST_ON} rcs_cs_e;
    rcs_cs_e        st_r;
    logic [SW-1:0]  cnt_r;
    wire            cnt_done = (cnt_r == '0);
    wire            want     = (cif.req_src != cif.cur_src);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_r        <= ST_RUN;
            cnt_r       <= '0;
            cif.cur_src <= SRC_INT;
            cif.gate_en <= 1'b1;
            cif.busy    <= 1'b0;
        end else begin
            if (!cnt_done)
                cnt_r <= cnt_r - 1'b1;
            case (st_r)
                ST_RUN: if (want) begin
                    st_r        <= ST_OFF;
                    cif.gate_en <= 1'b0; // [RULE9]
                    cif.busy    <= 1'b1;
                    cnt_r       <= SW'(SETTLE_CYC);
                end
                ST_OFF: if (cnt_done) begin
                    st_r        <= ST_ON;
                    cif.cur_src <= cif.req_src; // [RULE7] [RULE8]
                    cnt_r       <= SW'(SETTLE_CYC);
                end
                ST_ON: if (cnt_done) begin
                    st_r        <= ST_RUN;
                    cif.gate_en <= 1'b1;
                    cif.busy    <= 1'b0;
                end
                default: st_r <= ST_RUN;
            endcase
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_src_gated_change: assert property (!$stable(cif.cur_src) |-> !cif.gate_en && $past(!cif.gate_en)) // [RULE9]
        else $error("clock source changed with gate open");
    a_gate_settle_on: assert property ($rose(cif.gate_en) |-> $past(!cif.gate_en, 2) && $stable(cif.cur_src)) // [RULE9]
        else $error("clock gate reopened too early");
endmodule : rcs_clk_sel

// ---- design/rcs_reset_ctl.sv ----
// Purpose: Combines reset causes into one system reset and controls the clock source
// Assumes: rst_n is the power-on reset; pins and analog levels are asynchronous to mclk
// Notes:   Registers other than the clock request are reset by power-on only, so cause flags survive a system reset
`timescale 1ns/10ps
// Summary of operation
// (RULE1) Seven reset causes merged into system reset
// (RULE2) Reset pin takes external reset, drives power-on
// (RULE3) Causes maskable except supply monitor and pin
// (RULE4) Supply monitor enabled only by its pin
// (RULE5) Watchdog lockable on after power-on, permanently
// (RULE6) Every reset selects internal oscillator
// (RULE7) Software switches internal and external oscillator
// (RULE8) PLL offered as further clock source
// (RULE9) Glitch-free switch; reset held while cause active
module rcs_reset_ctl import rcs_pkg::*; #(
    parameter int HOLD_CYC   = RST_HOLD_CYC,
    parameter int SETTLE_CYC = CLK_SETTLE_CYC
) (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       supply_low,
    input  wire logic       supply_monitor_enable_pin,
    input  wire logic       wdt_expire,
    input  wire logic       clk_missing,
    input  wire logic       cmp0_trip,
    input  wire logic       conversion_start_input_0,
    input  wire logic       ext_rst_n_i,
    output logic            ext_rst_n_o,
    output logic            ext_rst_oe_n,
    output logic            sys_rst_n,
    output logic      [1:0] clk_src,
    output logic            clk_gate_en,
    output logic            irq
);
    localparam int CW = $clog2(HOLD_CYC + 1);

    // One address compare shared by the write and read decode
    function automatic logic addr_is(input logic [3:0] a, input logic [3:0] sel);
        return a == sel;
    endfunction : addr_is

    logic [5:0]    sync1_r;
    logic [5:0]    sync2_r;
    logic [7:0]    prev_r;
    logic [7:0]    stat_r;
    logic [7:0]    mask_r;
    logic [4:0]    en_r;
    logic          lock_r;
    logic          por_flag_r;
    logic          drv_r;
    logic [1:0]    drv_d_r;
    logic [CW-1:0] hold_r;
    logic          sys_rst_n_r;
    logic          irq_r;
    logic          pin_o_r;
    logic [7:0]    rdata_r;
    rcs_src_e      clk_req_r;

    rcs_clk_if cif ();

    rcs_clk_sel #(.SETTLE_CYC(SETTLE_CYC)) u_sel (
        .mclk  (mclk),
        .rst_n (rst_n),
        .cif   (cif)
    );

    // Register decode
    wire wr_ctrl = reg_wr && addr_is(reg_addr, ADDR_CTRL);
    wire wr_en   = reg_wr && addr_is(reg_addr, ADDR_EN);
    wire wr_clk  = reg_wr && addr_is(reg_addr, ADDR_CLK);
    wire wr_stat = reg_wr && addr_is(reg_addr, ADDR_STAT);
    wire wr_mask = reg_wr && addr_is(reg_addr, ADDR_MASK);
    wire sw_req  = wr_ctrl && reg_wdata[CTRL_SWRST];

    // Monitor and watchdog enable levels
    wire mon_on   = sync2_r[S_MON];
    wire wdt_on   = en_r[EN_WDT] | lock_r; // [RULE5]
    // Own pin drive is ignored until it has left the synchroniser
    wire self_drv = drv_r | (|drv_d_r);

    wire sup_act  = sync2_r[S_SUP] & mon_on; // [RULE4]
    wire ext_act  = ~sync2_r[S_EXT] & ~self_drv; // [RULE2]
    wire wdt_act  = wdt_expire & wdt_on; // [RULE3]
    wire mcd_act  = sync2_r[S_MCD] & en_r[EN_MCD]; // [RULE3]
    wire cmp_act  = sync2_r[S_CMP] & en_r[EN_CMP]; // [RULE3]
    wire sw_act   = sw_req & en_r[EN_SW]; // [RULE3]
    wire cnv_act  = sync2_r[S_CNV] & en_r[EN_CNV]; // [RULE3]

    wire [7:0] cause_vec = {ext_act, cnv_act, sw_act, cmp_act, mcd_act, wdt_act, sup_act, 1'b0}; // [RULE1]
    wire       cause_act = |cause_vec; // [RULE1]
    wire [7:0] cause_ev  = cause_vec & ~prev_r;

    wire [CW-1:0] hold_nxt = cause_act ? CW'(HOLD_CYC) :
                             (hold_r != '0) ? hold_r - 1'b1 : hold_r;
    wire          rst_nxt  = !cause_act && (hold_nxt == '0); // [RULE9]

    // Set wins over a write-one clear in the same cycle
    wire [7:0] stat_nxt = (stat_r & ~(wr_stat ? reg_wdata : 8'h00)) | cause_ev;

    wire [1:0] live_v = {mon_on, ~sync2_r[S_EXT]};
    wire [7:0] rd_mux =
        addr_is(reg_addr, ADDR_CTRL) ? {6'h00, lock_r, 1'b0} :
        addr_is(reg_addr, ADDR_EN)   ? {3'h0, en_r[4:1], wdt_on} :
        addr_is(reg_addr, ADDR_CLK)  ? {cif.busy, cif.gate_en, cif.cur_src, 2'h0, clk_req_r} :
        addr_is(reg_addr, ADDR_STAT) ? stat_r :
        addr_is(reg_addr, ADDR_MASK) ? mask_r :
        addr_is(reg_addr, ADDR_LIVE) ? {cause_vec[7:2], live_v} :
                                       8'h00;

    // Illegal source code 3 falls back to the internal oscillator
    wire rcs_src_e wr_src = (reg_wdata[1:0] == 2'h1) ? SRC_EXT :
                            (reg_wdata[1:0] == 2'h2) ? SRC_PLL : SRC_INT; // [RULE7] [RULE8]

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= 6'h00;
            sync2_r <= 6'h00;
        end else begin
            sync1_r <= {conversion_start_input_0, cmp0_trip, clk_missing,
                        supply_monitor_enable_pin, supply_low, ext_rst_n_i};
            sync2_r <= sync1_r;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hold_r      <= CW'(HOLD_CYC);
            sys_rst_n_r <= 1'b0;
            prev_r      <= 8'h00;
            drv_r       <= 1'b1;
            drv_d_r     <= 2'h3;
            pin_o_r     <= 1'b0;
        end else begin
            hold_r      <= hold_nxt;
            sys_rst_n_r <= rst_nxt; // [RULE1] [RULE9]
            prev_r      <= cause_vec;
            drv_d_r     <= {drv_d_r[0], drv_r};
            pin_o_r     <= 1'b0;
            if (rst_nxt)
                drv_r <= 1'b0; // [RULE2]
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stat_r     <= STAT_RST;
            mask_r     <= MASK_RST;
            en_r       <= EN_RST;
            lock_r     <= 1'b0;
            por_flag_r <= 1'b1;
            irq_r      <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            irq_r  <= |(stat_nxt & mask_r);
            if (wr_mask)
                mask_r <= reg_wdata;
            if (wr_en)
                en_r <= reg_wdata[4:0];
            if (!drv_r && cause_act)
                por_flag_r <= 1'b0;
            if (wr_ctrl && reg_wdata[CTRL_WLOCK] && por_flag_r)
                lock_r <= 1'b1; // [RULE5]
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            clk_req_r <= SRC_INT;
            rdata_r   <= 8'h00;
        end else begin
            rdata_r <= reg_rd ? rd_mux : 8'h00;
            if (!sys_rst_n_r)
                clk_req_r <= SRC_INT; // [RULE6]
            else if (wr_clk)
                clk_req_r <= wr_src; // [RULE7] [RULE8]
        end
    end

    assign cif.req_src  = clk_req_r;
    assign reg_rdata    = rdata_r;
    assign sys_rst_n    = sys_rst_n_r;
    assign irq          = irq_r;
    assign ext_rst_n_o  = pin_o_r;
    assign ext_rst_oe_n = ~drv_r;
    assign clk_src      = cif.cur_src;
    assign clk_gate_en  = cif.gate_en;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_cause_gone;
        !cause_act ##1 !cause_act;
    endsequence

    a_rst_while_cause: assert property (cause_act |=> !sys_rst_n_r) // [RULE9]
        else $error("system reset released while a cause is active");
    a_rst_hold_min: assert property ($rose(sys_rst_n_r) |-> $past(hold_r) <= CW'(1) && $past(!cause_act)) // [RULE9]
        else $error("system reset released before hold time");
    a_rst_release_by: assert property (s_cause_gone ##0 (hold_r == '0) |=> sys_rst_n_r) // [RULE1]
        else $error("system reset not released after hold");
    a_sup_unmaskable: assert property (sup_act |=> !sys_rst_n_r) // [RULE3]
        else $error("supply monitor trip did not reset");
    a_mon_pin_only: assert property (!$past(supply_monitor_enable_pin, 2) |-> !sup_act) // [RULE4]
        else $error("supply monitor active while its pin is low");
    a_ext_pin_reset: assert property (ext_act |=> !sys_rst_n_r ##1 !sys_rst_n_r) // [RULE2]
        else $error("external reset pin ignored");
    a_por_pin_drive: assert property (!ext_rst_oe_n |-> !sys_rst_n_r && !ext_rst_n_o) // [RULE2]
        else $error("pin driven outside power-on reset");
    a_cmp_masked: assert property (wr_en && !reg_wdata[EN_CMP] |=> !cause_vec[C_CMP]) // [RULE3]
        else $error("disabled comparator cause active");
    a_sw_reset_go: assert property (sw_act |=> !sys_rst_n_r) // [RULE1]
        else $error("software reset did not reset");
    a_wdt_lock_on: assert property (lock_r && wdt_expire |=> !sys_rst_n_r) // [RULE5]
        else $error("watchdog lock lost or watchdog off");
    a_lock_window: assert property ($rose(lock_r) |-> $past(por_flag_r)) // [RULE5]
        else $error("watchdog locked outside power-on window");
    a_clk_int_reset: assert property (!sys_rst_n_r |=> clk_req_r == SRC_INT) // [RULE6]
        else $error("clock request not internal after reset");
    a_clk_reach_req: assert property ($rose(cif.busy) ##1 $stable(clk_req_r)[*8] // [RULE7] [RULE8]
        |-> ##[0:8] cif.cur_src == clk_req_r)
        else $error("clock source did not follow request");
endmodule : rcs_reset_ctl

// ---- testbench/rcs_far_model.sv ----
// Purpose: Far-side model of supply, watchdog, detectors and the reset pin
// Assumes: The reset pin has a pull-up; ev bits 0 supply, 1 wdt, 2 mcd, 3 cmp, 4 conv, 5 pin
// Notes:   lv carries {monitor enable, cause levels 4:0}
`timescale 1ns/10ps
module rcs_far_model (
    input  wire logic [5:0] ev,
    input  wire logic       mon,
    input  wire logic       ext_rst_n_o,
    input  wire logic       ext_rst_oe_n,
    output logic      [5:0] lv,
    output logic            pin
);
    // Monitor enable is a pin level only, no register path
    assign lv = {mon, ev[4:0]};
    // Pull-up wins unless the device or the outside pulls low
    assign pin = ((!ext_rst_oe_n && !ext_rst_n_o) || ev[5]) ? 1'b0 : 1'b1;
endmodule : rcs_far_model

// ---- testbench/test_reset_and_clock_source_control.sv ----
// Purpose: Self-checking bench for the reset and clock source control block
// Assumes: Hold and settle counts shortened to 4 and 2 cycles
// Notes:   Random cause and enable mixes from a fixed xorshift seed
`timescale 1ns/10ps
module test_reset_and_clock_source_control import rcs_pkg::*;;
    logic        mclk, rst_n, reg_wr, reg_rd, mon, pin, lock, pg;
    logic        ext_rst_n_o, ext_rst_oe_n, sys_rst_n, clk_gate_en, irq;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata;
    logic [5:0]  ev, lv;
    logic [4:0]  en;
    logic [1:0]  clk_src, ps;
    logic [31:0] seed = 32'h4defe497;
    int          n_fail, checked, i, k;

    rcs_reset_ctl #(.HOLD_CYC(4), .SETTLE_CYC(2)) uut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .supply_low(lv[0]),
        .supply_monitor_enable_pin(lv[5]), .wdt_expire(lv[1]), .clk_missing(lv[2]), .cmp0_trip(lv[3]),
        .conversion_start_input_0(lv[4]), .ext_rst_n_i(pin), .ext_rst_n_o(ext_rst_n_o),
        .ext_rst_oe_n(ext_rst_oe_n), .sys_rst_n(sys_rst_n), .clk_src(clk_src), .clk_gate_en(clk_gate_en),
        .irq(irq));
    rcs_far_model far (.ev(ev), .mon(mon), .ext_rst_n_o(ext_rst_n_o), .ext_rst_oe_n(ext_rst_oe_n),
        .lv(lv), .pin(pin));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task close_out();
        $display("checks %0d failures %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out

    initial begin
        #3000000;
        n_fail++;
        close_out();
    end

    task chk(input string s, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s exp %h got %h", s, e, g);
        end
    endtask : chk

    task wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask : wr

    task rd(input logic [3:0] a, input logic [7:0] e, input string s);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1 chk(s, e, reg_rdata);
    endtask : rd

    task wait_hi();
        for (k = 0; k < 40 && sys_rst_n !== 1'b1; k++) begin
            @(posedge mclk);
            #1;
        end
        chk("rst_end", 8'h01, sys_rst_n);
    endtask : wait_hi

    // Cause held 8 cycles: reset must still be low at the end if it counts
    task hit(input int c, input logic e);
        @(posedge mclk);
        ev[c] <= 1'b1;
        repeat (8) @(posedge mclk);
        #1 chk("rst_held", !e, sys_rst_n);
        @(posedge mclk);
        ev[c] <= 1'b0;
        wait_hi();
    endtask : hit

    task irqc(input logic [3:0] a, input logic [7:0] v, input logic e);
        wr(a, v);
        repeat (2) @(posedge mclk);
        #1 chk("irq", e, irq);
    endtask : irqc

    function automatic logic exp_rst(input int c);
        case (c)
            0: return mon;
            1: return en[0] | lock;
            2: return en[1];
            3: return en[2];
            4: return en[4];
            default: return 1'b1;
        endcase
    endfunction : exp_rst

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs

    // Source may only change while the gate is closed
    always @(negedge mclk) begin
        if (rst_n && pg === 1'b1 && clk_gate_en === 1'b1 && clk_src !== ps) begin
            n_fail++;
            $display("BAD clk_src exp %h got %h", ps, clk_src);
        end
        pg = clk_gate_en;
        ps = clk_src;
    end

    initial begin
        {reg_wr, reg_rd, reg_addr, reg_wdata, ev, mon, lock} = '0;
        rst_n = 1'b0;
        repeat (12) @(posedge mclk);
        chk("pin_drive", 8'h00, {ext_rst_oe_n, ext_rst_n_o});
        rst_n <= 1'b1;
        wr(ADDR_CTRL, 8'h02);
        lock = 1'b1;
        #1 chk("por_hold", 8'h00, sys_rst_n);
        wait_hi();
        chk("pin_free", 8'h01, ext_rst_oe_n);
        chk("clk_int", 8'h00, clk_src);
        rd(ADDR_STAT, STAT_RST, "stat");
        rd(ADDR_EN, {3'h0, EN_RST}, "en");
        rd(4'hf, 8'h00, "unmapped");
        wr(ADDR_EN, 8'h00);
        en = 5'h00;
        rd(ADDR_EN, 8'h01, "en_lock");
        wr(ADDR_CTRL, 8'h01);
        repeat (4) @(posedge mclk);
        #1 chk("sw_off", 8'h01, sys_rst_n);
        rd(ADDR_CTRL, 8'h02, "lock");
        for (i = 0; i < 6; i++) hit(i, exp_rst(i));
        @(posedge mclk);
        mon <= 1'b1;
        hit(0, 1'b1);
        rd(ADDR_LIVE, 8'h02, "live");
        repeat (12) begin
            seed = xs(seed);
            en = seed[4:0];
            @(posedge mclk);
            mon <= seed[8];
            wr(ADDR_EN, {3'h0, en});
            wr(ADDR_STAT, 8'hff);
            i = seed[15:12] % 6;
            hit(i, exp_rst(i));
            rd(ADDR_STAT, exp_rst(i) ? 8'(1 << (i < 4 ? i + 1 : i + 2)) : 8'h00, "stat_flag");
        end
        for (i = 1; i < 3; i++) begin
            wr(ADDR_CLK, 8'(i));
            for (k = 0; k < 30 && clk_src !== 2'(i); k++) begin
                @(posedge mclk);
                #1;
            end
            repeat (4) @(posedge mclk);
            #1 chk("src", 8'(i), clk_src);
            rd(ADDR_CLK, 8'h40 | 8'(i << 4) | 8'(i), "clk_reg");
        end
        wr(ADDR_EN, 8'h08);
        wr(ADDR_STAT, 8'hff);
        wr(ADDR_MASK, 8'h20);
        wr(ADDR_CTRL, 8'h03);
        #1 chk("sw_rst", 8'h00, sys_rst_n);
        wait_hi();
        for (k = 0; k < 30 && clk_src !== 2'd0; k++) begin
            @(posedge mclk);
            #1;
        end
        chk("clk_back", 8'h00, clk_src);
        chk("irq_sw", 8'h01, irq);
        irqc(ADDR_MASK, 8'h00, 1'b0);
        irqc(ADDR_MASK, 8'h20, 1'b1);
        irqc(ADDR_STAT, 8'h20, 1'b0);
        wr(ADDR_CLK, 8'h03);
        rd(ADDR_CLK, 8'h40, "clk_code3");
        close_out();
    end
endmodule : test_reset_and_clock_source_control
